// >>> verilog/codec_offset_overflow_filter_regs.svh
`ifndef CODEC_OFFSET_OVERFLOW_FILTER_REGS_SVH
`define CODEC_OFFSET_OVERFLOW_FILTER_REGS_SVH
// ==========================================================
// Register offsets
`define OFFSET_REG_ADDR 8'h0a
`define FLAGS_REG_ADDR 8'h0b
`define FILTER_REG_ADDR 8'h0c
// ==========================================================
// Reset values
`define OFFSET_REG_RESET 8'h00
`define PLL_DIV_RESET 4'h1
`define FILTER_REG_RESET 8'h00
`define FLAGS_RESET 4'h0
`define READ_DATA_RESET 8'h00
// ==========================================================
// Field positions in the flag register
`define FLAG_ADC_LEFT_BIT 7
`define FLAG_ADC_RIGHT_BIT 6
`define FLAG_DAC_LEFT_BIT 5
`define FLAG_DAC_RIGHT_BIT 4
`define PLL_DIV_MSB 3
`define PLL_DIV_LSB 0
// ==========================================================
// Field positions in the filter register
`define HPF_LEFT_MSB 7
`define HPF_LEFT_LSB 6
`define HPF_RIGHT_MSB 5
`define HPF_RIGHT_LSB 4
`define EFFECTS_LEFT_BIT 3
`define DEEMPH_LEFT_BIT 2
`define EFFECTS_RIGHT_BIT 1
`define DEEMPH_RIGHT_BIT 0
// ==========================================================
// Largest legal offsets per transfer mode
`define OFFSET_MAX_CONT 8'h11
`define OFFSET_MAX_CONT_DSP 8'h10
`define OFFSET_MAX_256 8'hf2
`define OFFSET_MAX_256_DSP 8'hf1
`endif

// >>> verilog/codec_offset_overflow_filter_pkg.sv
package codec_offset_overflow_filter_pkg;
  typedef enum logic [1:0]
  {
    FMT_I2S = 2'h0,
    FMT_DSP = 2'h1,
    FMT_RIGHT_JUSTIFIED = 2'h2,
    FMT_LEFT_JUSTIFIED = 2'h3
  } serial_format_t;

  typedef enum logic [1:0]
  {
    HPF_OFF = 2'h0,
    HPF_FS_0045 = 2'h1,
    HPF_FS_0125 = 2'h2,
    HPF_FS_0250 = 2'h3
  } hpf_cutoff_t;
endpackage

// >>> verilog/codec_offset_overflow_filter_regs.sv
`timescale 1ns/100ps
`include "codec_offset_overflow_filter_regs.svh"

module codec_offset_overflow_filter_regs
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire codec_offset_overflow_filter_pkg::serial_format_t serialFormat,
  input wire logic bitClockIsOutput,
  input wire logic rate256Sel,
  input wire logic adcLeftOverflow,
  input wire logic adcRightOverflow,
  input wire logic dacLeftOverflow,
  input wire logic dacRightOverflow,
  output logic [7:0] wordOffset,
  output logic offsetFromWordClockRise,
  output logic frame256Mode,
  output logic [7:0] offsetLimit,
  output logic offsetLegal,
  output logic [4:0] pllDivider,
  output codec_offset_overflow_filter_pkg::hpf_cutoff_t leftHpfCutoff,
  output codec_offset_overflow_filter_pkg::hpf_cutoff_t rightHpfCutoff,
  output logic leftHpfEnable,
  output logic rightHpfEnable,
  output logic leftEffectsEnable,
  output logic leftDeemphEnable,
  output logic rightEffectsEnable,
  output logic rightDeemphEnable
);
  import codec_offset_overflow_filter_pkg::*;

  // ==========================================================
  // Register state
  logic [7:0] offset_reg, offset_next;
  logic [3:0] flags_reg, flags_next;
  logic [3:0] pllDiv_reg, pllDiv_next;
  logic [7:0] filter_reg, filter_next;
  logic [7:0] rdData_reg, rdData_next;
  logic [3:0] overflowIn;
  logic wrOffset, wrFlags, wrFilter, rdFlags;

  assign overflowIn = {adcLeftOverflow, adcRightOverflow, dacLeftOverflow, dacRightOverflow};
  assign wrOffset = regWrEn && (regAddr == `OFFSET_REG_ADDR);
  assign wrFlags = regWrEn && (regAddr == `FLAGS_REG_ADDR);
  assign wrFilter = regWrEn && (regAddr == `FILTER_REG_ADDR);
  assign rdFlags = regRdEn && (regAddr == `FLAGS_REG_ADDR);

  always_comb
  begin
    offset_next = offset_reg;
    pllDiv_next = pllDiv_reg;
    filter_next = filter_reg;
    if (wrOffset)
      offset_next = regWrData;
    if (wrFlags)
      pllDiv_next = regWrData[`PLL_DIV_MSB:`PLL_DIV_LSB];
    if (wrFilter)
      filter_next = regWrData;
    // Event beats the read clear so an overflow in the read cycle survives
    flags_next = (rdFlags ? 4'h0 : flags_reg) | overflowIn;
  end

  always_comb
  begin
    rdData_next = 8'h00;
    if (regRdEn)
    begin
      unique case (regAddr)
        `OFFSET_REG_ADDR: rdData_next = offset_reg;
        `FLAGS_REG_ADDR: rdData_next = {flags_reg, pllDiv_reg};
        `FILTER_REG_ADDR: rdData_next = filter_reg;
        default: rdData_next = 8'h00;
      endcase
    end
    else
      rdData_next = rdData_reg;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      offset_reg <= `OFFSET_REG_RESET;
      flags_reg <= `FLAGS_RESET;
      pllDiv_reg <= `PLL_DIV_RESET;
      filter_reg <= `FILTER_REG_RESET;
    end
    else
    begin
      offset_reg <= offset_next;
      flags_reg <= flags_next;
      pllDiv_reg <= pllDiv_next;
      filter_reg <= filter_next;
    end
  end

  // ==========================================================
  // Read data
  // Held until the next read, so a slow host may pick it up late
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rdData_reg <= `READ_DATA_RESET;
    end
    else
    begin
      rdData_reg <= rdData_next;
    end
  end

  // ==========================================================
  // Decoded controls
  always_comb
  begin
    frame256Mode = bitClockIsOutput && rate256Sel;
    offsetFromWordClockRise = (serialFormat == FMT_DSP);
    // Limits are advisory; the offset is stored whatever the host writes
    if (frame256Mode)
      offsetLimit = offsetFromWordClockRise ? `OFFSET_MAX_256_DSP : `OFFSET_MAX_256;
    else
      offsetLimit = offsetFromWordClockRise ? `OFFSET_MAX_CONT_DSP : `OFFSET_MAX_CONT;
  end

  assign wordOffset = offset_reg;
  assign offsetLegal = (offset_reg <= offsetLimit);
  assign pllDivider = (pllDiv_reg == 4'h0) ? 5'h10 : {1'b0, pllDiv_reg};
  assign leftHpfCutoff = hpf_cutoff_t'(filter_reg[`HPF_LEFT_MSB:`HPF_LEFT_LSB]);
  assign rightHpfCutoff = hpf_cutoff_t'(filter_reg[`HPF_RIGHT_MSB:`HPF_RIGHT_LSB]);
  assign leftHpfEnable = (leftHpfCutoff != HPF_OFF);
  assign rightHpfEnable = (rightHpfCutoff != HPF_OFF);
  assign leftEffectsEnable = filter_reg[`EFFECTS_LEFT_BIT];
  assign leftDeemphEnable = filter_reg[`DEEMPH_LEFT_BIT];
  assign rightEffectsEnable = filter_reg[`EFFECTS_RIGHT_BIT];
  assign rightDeemphEnable = filter_reg[`DEEMPH_RIGHT_BIT];
  assign regRdData = rdData_reg;

  // ==========================================================
  // Checks
  offset_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    wrOffset |=> (wordOffset == $past(regWrData)))
    else $error("offset write not stored");
  dsp_reference_a: assert property (@(posedge ref_clk) disable iff (rst)
    (serialFormat == FMT_DSP) |-> offsetFromWordClockRise
      && (offsetLimit == (frame256Mode ? 8'hf1 : 8'h10)))
    else $error("dsp offset reference wrong");
  limit_cont_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!frame256Mode && serialFormat != FMT_DSP) |-> (offsetLimit == 8'h11))
    else $error("continuous limit wrong");
  limit_256_a: assert property (@(posedge ref_clk) disable iff (rst)
    (frame256Mode && serialFormat == FMT_DSP) |-> (offsetLimit == 8'hf1))
    else $error("256 clock dsp limit wrong");
  left_adc_sticky_a: assert property (@(posedge ref_clk) disable iff (rst)
    adcLeftOverflow ##1 (!rdFlags && !adcLeftOverflow) [*2] |=> flags_reg[3])
    else $error("left adc flag not held");
  right_adc_sticky_a: assert property (@(posedge ref_clk) disable iff (rst)
    adcRightOverflow |=> flags_reg[2])
    else $error("right adc flag not set");
  dac_flags_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    (dacLeftOverflow && dacRightOverflow) |=> (flags_reg[1:0] == 2'h3))
    else $error("dac flags not set");
  read_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    (rdFlags && overflowIn == 4'h0) |=> (flags_reg == 4'h0 && regRdData[7:4] == $past(flags_reg)))
    else $error("flag read did not clear");
  pll_decode_a: assert property (@(posedge ref_clk) disable iff (rst)
    (wrFlags && regWrData[3:0] == 4'h0) |=> (pllDivider == 5'h10))
    else $error("divider code zero not sixteen");
  hpf_decode_a: assert property (@(posedge ref_clk) disable iff (rst)
    (wrFilter && regWrData[7:6] == 2'h0)
      |=> !leftHpfEnable && rightHpfCutoff == $past(regWrData[5:4]))
    else $error("highpass decode wrong");
  filter_bits_a: assert property (@(posedge ref_clk) disable iff (rst)
    wrFilter |=> ({leftEffectsEnable, leftDeemphEnable, rightEffectsEnable, rightDeemphEnable}
      == $past(regWrData[3:0])))
    else $error("filter enables not mapped");
  flag_read_spares_a: assert property (@(posedge ref_clk) disable iff (rst)
    (rdFlags && !wrFlags) |=> $stable(pllDivider))
    else $error("flag read changed divider");
  flag_write_spares_a: assert property (@(posedge ref_clk) disable iff (rst)
    (wrFlags && !rdFlags && overflowIn == 4'h0) |=> $stable(flags_reg))
    else $error("write altered flags");
  // Holds are checked over two quiet cycles after the event
  right_adc_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    adcRightOverflow ##1 (!rdFlags && !adcRightOverflow) [*2] |=> flags_reg[2])
    else $error("right adc flag not held");
  dac_left_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    dacLeftOverflow ##1 (!rdFlags && !dacLeftOverflow) [*2] |=> flags_reg[1])
    else $error("left dac flag not held");
  dac_right_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    dacRightOverflow ##1 (!rdFlags && !dacRightOverflow) [*2] |=> flags_reg[0])
    else $error("right dac flag not held");
  pll_code_a: assert property (@(posedge ref_clk) disable iff (rst)
    (wrFlags && regWrData[3:0] != 4'h0) |=> (pllDivider == {1'b0, $past(regWrData[3:0])}))
    else $error("divider code not passed through");
  right_hpf_off_a: assert property (@(posedge ref_clk) disable iff (rst)
    (wrFilter && regWrData[5:4] == 2'h0)
      |=> !rightHpfEnable && leftHpfCutoff == $past(regWrData[7:6]))
    else $error("right highpass decode wrong");
  offset_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    (regRdEn && regAddr == `OFFSET_REG_ADDR) |=> (regRdData == $past(wordOffset)))
    else $error("offset read wrong");
  flag_read_value_a: assert property (@(posedge ref_clk) disable iff (rst)
    rdFlags |=> (regRdData[3:0] == $past(pllDiv_reg)))
    else $error("flag read lost divider");
endmodule // codec_offset_overflow_filter_regs

// >>> verif/testbench.sv
`timescale 1ns/100ps
`include "codec_offset_overflow_filter_regs.svh"
module testbench;
  import codec_offset_overflow_filter_pkg::*;
  logic ref_clk, rst, regWrEn, regRdEn, bitClockIsOutput, rate256Sel, offsetLegal;
  logic adcLeftOverflow, adcRightOverflow, dacLeftOverflow, dacRightOverflow, frame256Mode;
  logic [7:0] regAddr, regWrData, regRdData, wordOffset, offsetLimit, rdVal;
  logic offsetFromWordClockRise, leftHpfEnable, rightHpfEnable;
  logic leftEffectsEnable, leftDeemphEnable, rightEffectsEnable, rightDeemphEnable;
  logic [4:0] pllDivider;
  serial_format_t serialFormat;
  hpf_cutoff_t leftHpfCutoff, rightHpfCutoff;
  int errTotal, nCompared;
  codec_offset_overflow_filter_regs u_dut (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
    .serialFormat(serialFormat), .bitClockIsOutput(bitClockIsOutput),
    .rate256Sel(rate256Sel), .adcLeftOverflow(adcLeftOverflow),
    .adcRightOverflow(adcRightOverflow), .dacLeftOverflow(dacLeftOverflow),
    .dacRightOverflow(dacRightOverflow), .wordOffset(wordOffset),
    .offsetFromWordClockRise(offsetFromWordClockRise), .frame256Mode(frame256Mode),
    .offsetLimit(offsetLimit), .offsetLegal(offsetLegal), .pllDivider(pllDivider),
    .leftHpfCutoff(leftHpfCutoff), .rightHpfCutoff(rightHpfCutoff),
    .leftHpfEnable(leftHpfEnable), .rightHpfEnable(rightHpfEnable),
    .leftEffectsEnable(leftEffectsEnable), .leftDeemphEnable(leftDeemphEnable),
    .rightEffectsEnable(rightEffectsEnable), .rightDeemphEnable(rightDeemphEnable));
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) {regWrEn, regAddr, regWrData} <= {1'b1, a, d};
    @(posedge ref_clk) regWrEn <= 1'b0;
    #1;
  endtask
  // Data lands one cycle after the read edge
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk) {regRdEn, regAddr} <= {1'b1, a};
    @(posedge ref_clk) regRdEn <= 1'b0;
    #1 rdVal = regRdData;
  endtask
  task automatic ovf(input logic [3:0] m);
    @(posedge ref_clk);
    {adcLeftOverflow, adcRightOverflow, dacLeftOverflow, dacRightOverflow} <= m;
    @(posedge ref_clk);
    {adcLeftOverflow, adcRightOverflow, dacLeftOverflow, dacRightOverflow} <= 4'h0;
    repeat (3) @(posedge ref_clk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic test_reset;
    chk({3'h0, pllDivider}, 8'h01);
    rd(`OFFSET_REG_ADDR);
    chk(rdVal, 8'h00);
    rd(`FLAGS_REG_ADDR);
    chk(rdVal, 8'h01);
    rd(`FILTER_REG_ADDR);
    chk(rdVal, 8'h00);
    rd(8'h0d);
    chk(rdVal, 8'h00);
    $display("test_reset done");
  endtask
  task automatic test_offset;
    logic [7:0] lim;
    wr(`OFFSET_REG_ADDR, 8'hff);
    chk(wordOffset, 8'hff);
    rd(`OFFSET_REG_ADDR);
    chk(rdVal, 8'hff);
    wr(`OFFSET_REG_ADDR, 8'h11);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge ref_clk);
      serialFormat <= serial_format_t'(i[3:2]);
      {bitClockIsOutput, rate256Sel} <= i[1:0];
      @(posedge ref_clk) #1;
      lim = (i[1] & i[0]) ? ((i[3:2] == 2'h1) ? 8'hf1 : 8'hf2)
                          : ((i[3:2] == 2'h1) ? 8'h10 : 8'h11);
      chk({7'h0, frame256Mode}, {7'h0, i[1] & i[0]});
      chk({7'h0, offsetFromWordClockRise}, {7'h0, i[3:2] == 2'h1});
      chk(offsetLimit, lim);
      chk({7'h0, offsetLegal}, {7'h0, lim >= 8'h11});
    end
    $display("test_offset done");
  endtask
  task automatic test_flags;
    for (int i = 0; i < 4; i++)
    begin
      ovf(4'h8 >> i);
      rd(`FLAGS_REG_ADDR);
      chk(rdVal, (8'h80 >> i) | 8'h01);
      rd(`FLAGS_REG_ADDR);
      chk(rdVal, 8'h01);
    end
    ovf(4'hf);
    wr(`FLAGS_REG_ADDR, 8'h00);
    chk({3'h0, pllDivider}, 8'h10);
    rd(`FLAGS_REG_ADDR);
    chk(rdVal, 8'hf0);
    wr(`FLAGS_REG_ADDR, 8'hf7);
    chk({3'h0, pllDivider}, 8'h07);
    rd(`FLAGS_REG_ADDR);
    chk(rdVal, 8'h07);
    $display("test_flags done");
  endtask
  task automatic test_filter;
    logic [7:0] d;
    for (int c = 0; c < 4; c++)
    begin
      d = {c[1:0], ~c[1:0], 4'h1 << c};
      wr(`FILTER_REG_ADDR, d);
      chk({6'h0, leftHpfCutoff}, {6'h0, d[7:6]});
      chk({6'h0, rightHpfCutoff}, {6'h0, d[5:4]});
      chk({6'h0, leftHpfEnable, rightHpfEnable}, {6'h0, d[7:6] != 0, d[5:4] != 0});
      chk({4'h0, leftEffectsEnable, leftDeemphEnable, rightEffectsEnable, rightDeemphEnable},
          {4'h0, d[3:0]});
      rd(`FILTER_REG_ADDR);
      chk(rdVal, d);
    end
    $display("test_filter done");
  endtask
  task automatic test_midreset;
    wr(`OFFSET_REG_ADDR, 8'h5a);
    wr(`FILTER_REG_ADDR, 8'hff);
    wr(`FLAGS_REG_ADDR, 8'h03);
    ovf(4'hf);
    @(posedge ref_clk) rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk(wordOffset, 8'h00);
    chk({3'h0, pllDivider}, 8'h01);
    chk({6'h0, leftHpfEnable, rightHpfEnable}, 8'h00);
    chk({4'h0, leftEffectsEnable, leftDeemphEnable, rightEffectsEnable, rightDeemphEnable},
        8'h00);
    rd(`FLAGS_REG_ADDR);
    chk(rdVal, 8'h01);
    rd(`FILTER_REG_ADDR);
    chk(rdVal, 8'h00);
    $display("test_midreset done");
  endtask
  // ==========================================================
  // Run control
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial
  begin
    #200000;
    errTotal++;
    give_verdict();
  end
  initial
  begin
    {rst, regWrEn, regRdEn, regAddr, regWrData} = {1'b1, 18'h0};
    serialFormat = FMT_I2S;
    {bitClockIsOutput, rate256Sel} = 2'h0;
    {adcLeftOverflow, adcRightOverflow, dacLeftOverflow, dacRightOverflow} = 4'h0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    test_reset();
    test_offset();
    test_flags();
    test_filter();
    test_midreset();
    give_verdict();
  end
endmodule // testbench
